// ===== design/cpu_pointer_bank_status_regs.sv
// pointer, register bank and status word register set of the core
`timescale 1ns/1ps
`default_nettype none

module cpu_pointer_bank_status_regs (
  input  wire logic                          CLK,
  input  wire logic                          ARST_N,
  // register port
  input  wire logic [7:0]                    SFR_ADDR,
  input  wire logic                          SFR_WE,
  input  wire logic [7:0]                    SFR_WDATA,
  output logic      [7:0]                    SFR_RDATA,
  output logic                               SFR_HIT,
  // bit instruction port
  input  wire logic [7:0]                    BIT_ADDR,
  input  wire logic                          BIT_WE,
  input  wire logic                          BIT_WDATA,
  output logic                               BIT_RDATA,
  output logic                               BIT_HIT,
  // internal data space port
  input  wire logic [7:0]                    DATA_ADDR,
  input  wire logic                          DATA_WE,
  input  wire logic [7:0]                    DATA_WDATA,
  output logic      [7:0]                    DATA_RDATA,
  output logic                               DATA_HIT,
  // unified memory map port
  input  wire logic [15:0]                   XDATA_ADDR,
  input  wire logic                          XDATA_WE,
  input  wire logic [7:0]                    XDATA_WDATA,
  output logic      [7:0]                    XDATA_RDATA,
  output logic                               XDATA_HIT,
  // working register port, relative to the active bank
  input  wire logic [2:0]                    REG_NUM,
  input  wire logic                          REG_WE,
  input  wire logic [7:0]                    REG_WDATA,
  output logic      [7:0]                    REG_RDATA,
  // arithmetic flag update
  input  wire logic                          ALU_UPDATE,
  input  wire cpu_regs_pkg::alu_flags_type   ALU_FLAGS,
  input  wire logic [7:0]                    ACC_VALUE,
  // pointer use by instructions
  input  wire logic                          PTR_WE,
  input  wire logic [15:0]                   PTR_WDATA,
  output logic      [15:0]                   ACTIVE_POINTER,
  output cpu_regs_pkg::status_word_type      STATUS_WORD
);

  cpu_regs_pkg::pointer_type     pointer_a;
  cpu_regs_pkg::pointer_type     pointer_b;
  cpu_regs_pkg::pointer_type     next_pointer_a;
  cpu_regs_pkg::pointer_type     next_pointer_b;
  logic                          pointer_choice;
  logic                          next_pointer_choice;
  cpu_regs_pkg::status_word_type status;
  cpu_regs_pkg::status_word_type next_status;
  logic [4:0]                    reg_index;
  logic                          data_in_bank;
  logic                          xdata_in_bank;
  logic                          bit_in_status;
  logic                          mem_we;
  logic [4:0]                    mem_waddr;
  logic [7:0]                    mem_wdata;
  logic                          status_byte_write;
  logic                          status_bit_write;

  // refuse package constants that the index arithmetic below cannot serve
  if (cpu_regs_pkg::BANK_COUNT * cpu_regs_pkg::REGS_PER_BANK != cpu_regs_pkg::BANK_WORDS) begin : bad_bank_count
    $error("cpu_pointer_bank_status_regs: bank count times bank size differs from the word count");
  end
  if ((1 << cpu_regs_pkg::BANK_ADR_W) != cpu_regs_pkg::BANK_WORDS) begin : bad_bank_index
    $error("cpu_pointer_bank_status_regs: bank index width does not cover the bank words exactly");
  end
  if ((1 << cpu_regs_pkg::REG_NUM_W) != cpu_regs_pkg::REGS_PER_BANK) begin : bad_reg_number
    $error("cpu_pointer_bank_status_regs: register number width does not match the bank size");
  end
  if (cpu_regs_pkg::BYTE_W != 8 || cpu_regs_pkg::POINTER_W != 2 * cpu_regs_pkg::BYTE_W) begin : bad_widths
    $error("cpu_pointer_bank_status_regs: pointers must be two bytes of eight bits");
  end

  // unified address falls in the bank alias window
  function automatic logic xdata_hits_bank(input logic [15:0] addr);
    return (addr >= cpu_regs_pkg::XDATA_BANK_FIRST) && (addr <= cpu_regs_pkg::XDATA_BANK_LAST);
  endfunction

  // data address falls in the bank window
  function automatic logic data_hits_bank(input logic [7:0] addr);
    return (addr >= cpu_regs_pkg::DATA_BANK_FIRST) && (addr <= cpu_regs_pkg::DATA_BANK_LAST);
  endfunction

  // bit address falls on one of the status word bits
  function automatic logic bit_hits_status(input logic [7:0] addr);
    return (addr >= cpu_regs_pkg::STATUS_BIT_BASE) && (addr <= cpu_regs_pkg::STATUS_BIT_LAST);
  endfunction

  // bank number and register number form the storage index
  function automatic logic [4:0] bank_index(input logic [1:0] bank, input logic [2:0] num);
    return {bank, num};
  endfunction

  // register read view for a register address
  function automatic logic [7:0] sfr_view(input logic [7:0] addr);
    case (addr)
      cpu_regs_pkg::SFR_POINTER_A_LOW:  return pointer_a.low_byte;
      cpu_regs_pkg::SFR_POINTER_A_HIGH: return pointer_a.high_byte;
      cpu_regs_pkg::SFR_POINTER_B_LOW:  return pointer_b.low_byte;
      cpu_regs_pkg::SFR_POINTER_B_HIGH: return pointer_b.high_byte;
      cpu_regs_pkg::SFR_POINTER_CHOICE: return {7'h00, pointer_choice};
      cpu_regs_pkg::SFR_STATUS_WORD:    return status;
      default:                          return 8'h00;
    endcase
  endfunction

  // register address is one that this block owns
  function automatic logic sfr_owned(input logic [7:0] addr);
    case (addr)
      cpu_regs_pkg::SFR_POINTER_A_LOW,
      cpu_regs_pkg::SFR_POINTER_A_HIGH,
      cpu_regs_pkg::SFR_POINTER_B_LOW,
      cpu_regs_pkg::SFR_POINTER_B_HIGH,
      cpu_regs_pkg::SFR_POINTER_CHOICE,
      cpu_regs_pkg::SFR_STATUS_WORD:    return 1'b1;
      default:                          return 1'b0;
    endcase
  endfunction

  // address decode of the three bank paths
  assign data_in_bank  = data_hits_bank(DATA_ADDR);
  assign xdata_in_bank = xdata_hits_bank(XDATA_ADDR);
  assign bit_in_status = bit_hits_status(BIT_ADDR);
  assign reg_index     = bank_index(status.bank_choice, REG_NUM);

  // software writes that reach the status word this cycle
  assign status_byte_write = SFR_WE && (SFR_ADDR == cpu_regs_pkg::SFR_STATUS_WORD);
  assign status_bit_write  = BIT_WE && bit_in_status;

  // single bank write port: working register, then data space, then unified map
  // only one write reaches the storage per cycle, so a losing write on another path is dropped
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = 5'h00;
    mem_wdata = 8'h00;
    if (REG_WE) begin
      mem_we    = 1'b1;
      mem_waddr = reg_index;
      mem_wdata = REG_WDATA;
    end else if (DATA_WE && data_in_bank) begin
      mem_we    = 1'b1;
      mem_waddr = DATA_ADDR[4:0];
      mem_wdata = DATA_WDATA;
    end else if (XDATA_WE && xdata_in_bank) begin
      mem_we    = 1'b1;
      mem_waddr = XDATA_ADDR[4:0];
      mem_wdata = XDATA_WDATA;
    end
  end

  // the thirty-two bank registers
  // three read ports let the data, unified and working register paths answer in one cycle
  // read data are registered, so a read in the cycle of a write shows the old word
  bank_reg_memory #(
    .WIDTH (cpu_regs_pkg::BYTE_W),
    .DEPTH (cpu_regs_pkg::BANK_WORDS),
    .ADR_W (cpu_regs_pkg::BANK_ADR_W)
  ) u_banks (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .wr_en     (mem_we),
    .wr_addr   (mem_waddr),
    .wr_data   (mem_wdata),
    .rd_addr_a (DATA_ADDR[4:0]),
    .rd_addr_b (XDATA_ADDR[4:0]),
    .rd_addr_c (reg_index),
    .rd_data_a (DATA_RDATA),
    .rd_data_b (XDATA_RDATA),
    .rd_data_c (REG_RDATA)
  );

  // pointer bytes and choice bit: register writes, then instruction writes on the chosen pointer
  // an instruction write lands on the pointer named before the edge, so a choice change
  // written in the same cycle does not redirect it
  always_comb begin
    next_pointer_a      = pointer_a;
    next_pointer_b      = pointer_b;
    next_pointer_choice = pointer_choice;
    if (SFR_WE) begin
      case (SFR_ADDR)
        cpu_regs_pkg::SFR_POINTER_A_LOW:  next_pointer_a.low_byte  = SFR_WDATA;
        cpu_regs_pkg::SFR_POINTER_A_HIGH: next_pointer_a.high_byte = SFR_WDATA;
        cpu_regs_pkg::SFR_POINTER_B_LOW:  next_pointer_b.low_byte  = SFR_WDATA;
        cpu_regs_pkg::SFR_POINTER_B_HIGH: next_pointer_b.high_byte = SFR_WDATA;
        cpu_regs_pkg::SFR_POINTER_CHOICE: next_pointer_choice = SFR_WDATA[cpu_regs_pkg::CHOICE_POS];
        default: ;
      endcase
    end
    if (PTR_WE) begin
      if (pointer_choice) begin
        next_pointer_b = PTR_WDATA;
      end else begin
        next_pointer_a = PTR_WDATA;
      end
    end
  end

  // pointer storage
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pointer_a      <= {cpu_regs_pkg::POINTER_RESET, cpu_regs_pkg::POINTER_RESET};
      pointer_b      <= {cpu_regs_pkg::POINTER_RESET, cpu_regs_pkg::POINTER_RESET};
      pointer_choice <= cpu_regs_pkg::CHOICE_RESET[cpu_regs_pkg::CHOICE_POS];
    end else begin
      pointer_a      <= next_pointer_a;
      pointer_b      <= next_pointer_b;
      pointer_choice <= next_pointer_choice;
    end
  end

  // active pointer follows the choice bit as it will stand after this edge
  // taking the next values keeps it in step with the byte registers, with no extra cycle of lag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ACTIVE_POINTER <= 16'h0000;
    end else begin
      ACTIVE_POINTER <= next_pointer_choice ? next_pointer_b : next_pointer_a;
    end
  end

  // status word: whole-byte write, then single-bit write, then arithmetic flags
  // arithmetic flags win over software writes in the same cycle
  always_comb begin
    next_status = status;
    if (status_byte_write) begin
      next_status = SFR_WDATA;
    end
    if (status_bit_write) begin
      next_status[BIT_ADDR[2:0]] = BIT_WDATA;
    end
    if (ALU_UPDATE) begin
      next_status.carry_flag        = ALU_FLAGS.carry_flag;
      next_status.nibble_carry_flag = ALU_FLAGS.nibble_carry_flag;
      next_status.overflow_flag     = ALU_FLAGS.overflow_flag;
    end
    // software writes to parity are overridden by the accumulator
    next_status.parity = ^ACC_VALUE;
  end

  // status storage
  // bank bits written here steer the working register port from the next cycle on
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= cpu_regs_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  assign STATUS_WORD = status;

  // registered read answers for the register and bit ports
  // addresses this block does not own answer zero with the hit flag low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SFR_RDATA <= 8'h00;
      SFR_HIT   <= 1'b0;
      BIT_RDATA <= 1'b0;
      BIT_HIT   <= 1'b0;
    end else begin
      SFR_RDATA <= sfr_view(SFR_ADDR);
      SFR_HIT   <= sfr_owned(SFR_ADDR);
      BIT_RDATA <= bit_in_status ? status[BIT_ADDR[2:0]] : 1'b0;
      BIT_HIT   <= bit_in_status;
    end
  end

  // registered hit flags for the bank windows, aligned with the memory read data
  // raw read data show an alias word outside the window, so users qualify it with the hit flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_HIT  <= 1'b0;
      XDATA_HIT <= 1'b0;
    end else begin
      DATA_HIT  <= data_in_bank;
      XDATA_HIT <= xdata_in_bank;
    end
  end

endmodule

`default_nettype wire

// ===== design/cpu_regs_pkg.sv
// constants and carrier types shared by the pointer, bank and status register set
package cpu_regs_pkg;

  // data widths
  localparam int BYTE_W     = 8;
  localparam int POINTER_W  = 16;
  localparam int BANK_ADR_W = 5;
  localparam int REG_NUM_W  = 3;

  // bank geometry: four banks of eight registers
  localparam int BANK_COUNT    = 4;
  localparam int REGS_PER_BANK = 8;
  localparam int BANK_WORDS    = 32;

  // special function register offsets
  localparam logic [7:0] SFR_POINTER_A_LOW  = 8'h82;
  localparam logic [7:0] SFR_POINTER_A_HIGH = 8'h83;
  localparam logic [7:0] SFR_POINTER_B_LOW  = 8'h84;
  localparam logic [7:0] SFR_POINTER_B_HIGH = 8'h85;
  localparam logic [7:0] SFR_POINTER_CHOICE = 8'h92;
  localparam logic [7:0] SFR_STATUS_WORD    = 8'hd0;

  // bit addresses of the status word: base plus bit position
  localparam logic [7:0] STATUS_BIT_BASE = 8'hd0;
  localparam logic [7:0] STATUS_BIT_LAST = 8'hd7;

  // bank windows in internal data space and in the unified map
  localparam logic [7:0]  DATA_BANK_FIRST  = 8'h00;
  localparam logic [7:0]  DATA_BANK_LAST   = 8'h1f;
  localparam logic [15:0] XDATA_BANK_FIRST = 16'hff00;
  localparam logic [15:0] XDATA_BANK_LAST  = 16'hff1f;

  // status word field positions
  localparam int CARRY_POS        = 7;
  localparam int NIBBLE_CARRY_POS = 6;
  localparam int USER_HI_POS      = 5;
  localparam int BANK_HI_POS      = 4;
  localparam int BANK_LO_POS      = 3;
  localparam int OVERFLOW_POS     = 2;
  localparam int USER_LO_POS      = 1;
  localparam int PARITY_POS       = 0;

  // pointer choice field position
  localparam int CHOICE_POS = 0;

  // reset values
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] CHOICE_RESET  = 8'h00;
  localparam logic [1:0] BANK_RESET    = 2'h0;

  // status word, bit 7 down to bit 0
  typedef struct packed {
    logic       carry_flag;
    logic       nibble_carry_flag;
    logic       user_flag_hi;
    logic [1:0] bank_choice;
    logic       overflow_flag;
    logic       user_flag_lo;
    logic       parity;
  } status_word_type;

  // flags delivered by the arithmetic unit with an update strobe
  typedef struct packed {
    logic carry_flag;
    logic nibble_carry_flag;
    logic overflow_flag;
  } alu_flags_type;

  // one data pointer as high and low byte
  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } pointer_type;

endpackage

// ===== design/bank_reg_memory.sv
// general register bank storage: one write port, three registered read ports
`timescale 1ns/1ps
`default_nettype none

module bank_reg_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int ADR_W = 5
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             wr_en,
  input  wire logic [ADR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [ADR_W-1:0] rd_addr_a,
  input  wire logic [ADR_W-1:0] rd_addr_b,
  input  wire logic [ADR_W-1:0] rd_addr_c,
  output logic      [WIDTH-1:0] rd_data_a,
  output logic      [WIDTH-1:0] rd_data_b,
  output logic      [WIDTH-1:0] rd_data_c
);

  // refuse shapes the address width cannot reach
  if (WIDTH < 1 || DEPTH < 1 || DEPTH > (1 << ADR_W)) begin : bad_shape
    $error("bank_reg_memory: depth does not fit the address width");
  end

  logic [WIDTH-1:0] words [DEPTH];

  // storage, cleared on reset like the rest of the core
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        words[i] <= '0;
      end
    end else if (wr_en) begin
      words[wr_addr] <= wr_data;
    end
  end

  // registered reads show the value before a same-cycle write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
      rd_data_c <= '0;
    end else begin
      rd_data_a <= words[rd_addr_a];
      rd_data_b <= words[rd_addr_b];
      rd_data_c <= words[rd_addr_c];
    end
  end

endmodule

`default_nettype wire

// ===== tb/cpu_regs_sva.sv
// assertion checker for the pointer, bank and status register set
`timescale 1ns/1ps
`default_nettype none
module cpu_regs_sva (
  input wire logic                        CLK,
  input wire logic                        ARST_N,
  input wire logic [7:0]                  SFR_ADDR,
  input wire logic                        SFR_WE,
  input wire logic [7:0]                  SFR_WDATA,
  input wire logic [7:0]                  SFR_RDATA,
  input wire logic                        SFR_HIT,
  input wire logic [7:0]                  BIT_ADDR,
  input wire logic                        BIT_WE,
  input wire logic                        BIT_HIT,
  input wire logic [7:0]                  DATA_ADDR,
  input wire logic                        DATA_HIT,
  input wire logic [15:0]                 XDATA_ADDR,
  input wire logic                        XDATA_HIT,
  input wire logic                        ALU_UPDATE,
  input wire cpu_regs_pkg::alu_flags_type ALU_FLAGS,
  input wire logic [7:0]                  ACC_VALUE,
  input wire logic                        PTR_WE,
  input wire cpu_regs_pkg::status_word_type STATUS_WORD
);
  // owned register offsets
  wire logic sfr_owned = SFR_ADDR inside {8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'hd0};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // write then read of the second pointer low byte
  sequence s_low_b_wr; SFR_WE && !PTR_WE && SFR_ADDR == 8'h84; endsequence
  sequence s_low_b_rd; !SFR_WE && SFR_ADDR == 8'h84; endsequence
  // cycle with no software write to the status word
  sequence s_no_stat_wr; !(SFR_WE && SFR_ADDR == 8'hd0) && !(BIT_WE && BIT_ADDR inside {[8'hd0:8'hd7]}); endsequence

  property p_ptr_b_low; s_low_b_wr ##1 s_low_b_rd |=> SFR_RDATA == $past(SFR_WDATA, 2); endproperty
  property p_sfr_hit; 1'b1 |=> SFR_HIT == $past(sfr_owned) && (SFR_HIT || SFR_RDATA == 8'h00); endproperty
  property p_bit_hit; 1'b1 |=> BIT_HIT == $past(BIT_ADDR inside {[8'hd0:8'hd7]}); endproperty
  property p_data_hit; 1'b1 |=> DATA_HIT == $past(DATA_ADDR <= 8'h1f); endproperty
  property p_xdata_hit; 1'b1 |=> XDATA_HIT == $past(XDATA_ADDR inside {[16'hff00:16'hff1f]}); endproperty
  property p_parity; 1'b1 |=> STATUS_WORD.parity == ^$past(ACC_VALUE); endproperty
  property p_alu;
    ALU_UPDATE |=> {STATUS_WORD.carry_flag, STATUS_WORD.nibble_carry_flag, STATUS_WORD.overflow_flag} == $past(ALU_FLAGS);
  endproperty
  property p_user_hold; s_no_stat_wr |=> $stable({STATUS_WORD.user_flag_hi, STATUS_WORD.user_flag_lo}); endproperty
  property p_bank_hold; s_no_stat_wr |=> $stable(STATUS_WORD.bank_choice); endproperty

  a_ptr_b_low: assert property (p_ptr_b_low) else $error("pointer b low byte read back wrong");
  a_sfr_hit: assert property (p_sfr_hit) else $error("register hit or unmapped read wrong");
  a_bit_hit: assert property (p_bit_hit) else $error("bit hit wrong");
  a_data_hit: assert property (p_data_hit) else $error("data window hit wrong");
  a_xdata_hit: assert property (p_xdata_hit) else $error("unified window hit wrong");
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  a_alu: assert property (p_alu) else $error("arithmetic flags not loaded");
  a_user_hold: assert property (p_user_hold) else $error("user flags changed unasked");
  a_bank_hold: assert property (p_bank_hold) else $error("bank choice changed unasked");
endmodule

bind cpu_pointer_bank_status_regs cpu_regs_sva chk (.CLK, .ARST_N, .SFR_ADDR, .SFR_WE, .SFR_WDATA, .SFR_RDATA,
  .SFR_HIT, .BIT_ADDR, .BIT_WE, .BIT_HIT, .DATA_ADDR, .DATA_HIT, .XDATA_ADDR, .XDATA_HIT, .ALU_UPDATE,
  .ALU_FLAGS, .ACC_VALUE, .PTR_WE, .STATUS_WORD);
`default_nettype wire

// ===== tb/testbench.sv
// self-checking testbench for the pointer, bank and status register set
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CLK, ARST_N, SFR_WE, SFR_HIT, BIT_WE, BIT_WDATA, BIT_RDATA, BIT_HIT;
  logic        DATA_WE, DATA_HIT, XDATA_WE, XDATA_HIT, REG_WE, ALU_UPDATE, PTR_WE;
  logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA, BIT_ADDR, DATA_ADDR, DATA_WDATA, DATA_RDATA;
  logic [7:0]  XDATA_WDATA, XDATA_RDATA, REG_WDATA, REG_RDATA, ACC_VALUE;
  logic [2:0]  REG_NUM;
  logic [15:0] XDATA_ADDR, PTR_WDATA, ACTIVE_POINTER;
  cpu_regs_pkg::alu_flags_type   ALU_FLAGS;
  cpu_regs_pkg::status_word_type STATUS_WORD;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [7:0]  offsets [6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'hd0};

  cpu_pointer_bank_status_regs uut (.CLK, .ARST_N, .SFR_ADDR, .SFR_WE, .SFR_WDATA, .SFR_RDATA, .SFR_HIT,
    .BIT_ADDR, .BIT_WE, .BIT_WDATA, .BIT_RDATA, .BIT_HIT, .DATA_ADDR, .DATA_WE, .DATA_WDATA, .DATA_RDATA,
    .DATA_HIT, .XDATA_ADDR, .XDATA_WE, .XDATA_WDATA, .XDATA_RDATA, .XDATA_HIT, .REG_NUM, .REG_WE,
    .REG_WDATA, .REG_RDATA, .ALU_UPDATE, .ALU_FLAGS, .ACC_VALUE, .PTR_WE, .PTR_WDATA, .ACTIVE_POINTER,
    .STATUS_WORD);

  // 50 MHz core clock
  always #10 CLK = ~CLK;

  // hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  task final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // port p: 0 register, 1 bit, 2 data, 3 unified, 4 working reg, 5 flags, 6 pointer, 7 accumulator
  task drive(input int p, input logic we, input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK);
    SFR_WE = we && p == 0;
    BIT_WE = we && p == 1;
    DATA_WE = we && p == 2;
    XDATA_WE = we && p == 3;
    REG_WE = we && p == 4;
    ALU_UPDATE = we && p == 5;
    PTR_WE = we && p == 6;
    {SFR_ADDR, BIT_ADDR, DATA_ADDR, XDATA_ADDR, REG_NUM, PTR_WDATA} = {a[7:0], a[7:0], a[7:0], a, a[2:0], a};
    {SFR_WDATA, DATA_WDATA, XDATA_WDATA, REG_WDATA, BIT_WDATA, ALU_FLAGS} = {d, d, d, d, d[0], d[2:0]};
    if (p == 7)
      ACC_VALUE = d;
  endtask

  // write strobe held for exactly one edge
  task put(input int p, input logic [15:0] a, input logic [7:0] d);
    drive(p, 1'b1, a, d);
  endtask

  // address held, outputs settled one edge later
  task look(input int p, input logic [15:0] a);
    drive(p, 1'b0, a, 8'h00);
    @(negedge CLK);
  endtask

  task rst();
    @(negedge CLK);
    ARST_N = 1'b0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    ARST_N = 1'b1;
  endtask

  initial begin
    CLK = 1'b0;
    ARST_N = 1'b0;
    {SFR_ADDR, SFR_WE, SFR_WDATA, BIT_ADDR, BIT_WE, BIT_WDATA, DATA_ADDR, DATA_WE, DATA_WDATA, XDATA_ADDR,
     XDATA_WE, XDATA_WDATA, REG_NUM, REG_WE, REG_WDATA, ALU_UPDATE, ALU_FLAGS, PTR_WE, PTR_WDATA, ACC_VALUE} = '0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    ARST_N = 1'b1;
    // reset values and unmapped offset
    foreach (offsets[i]) begin
      look(0, {8'h00, offsets[i]});
      chk(SFR_RDATA, 8'h00);
      chk(SFR_HIT, 1'b1);
    end
    look(0, 16'h0093);
    chk(SFR_HIT, 1'b0);
    // pointer bytes, choice and whole-pointer write
    put(0, 16'h0082, 8'h11);
    put(0, 16'h0083, 8'h22);
    put(0, 16'h0085, 8'h44);
    put(0, 16'h0084, 8'h33);
    look(0, 16'h0084);
    chk(SFR_RDATA, 8'h33);
    put(0, 16'h0092, 8'hff);
    look(0, 16'h0092);
    chk(SFR_RDATA, 8'h01);
    chk(ACTIVE_POINTER, 16'h4433);
    put(6, 16'hbeef, 8'h00);
    put(0, 16'h0092, 8'h00);
    look(0, 16'h0083);
    chk(SFR_RDATA, 8'h22);
    chk(ACTIVE_POINTER, 16'h2211);
    look(0, 16'h0085);
    chk(SFR_RDATA, 8'hbe);
    put(6, 16'hcafe, 8'h00);
    look(0, 16'h0082);
    chk(SFR_RDATA, 8'hfe);
    chk(ACTIVE_POINTER, 16'hcafe);
    // every bank code, seen through both windows
    for (int b = 0; b < 4; b++) begin
      put(0, 16'h00d0, 8'(b << 3));
      put(4, 16'h0005, 8'(8'ha0 + b));
      look(2, 16'(8 * b + 5));
      chk(DATA_RDATA, 8'(8'ha0 + b));
      look(3, 16'(16'hff05 + 8 * b));
      chk(XDATA_RDATA, 8'(8'ha0 + b));
      chk(XDATA_HIT, 1'b1);
    end
    // alias writes and refused out-of-window writes
    put(3, 16'hff1f, 8'h5c);
    look(4, 16'h0007);
    chk(REG_RDATA, 8'h5c);
    put(2, 16'h0020, 8'h77);
    put(3, 16'hfe00, 8'h66);
    look(2, 16'h0020);
    chk(DATA_HIT, 1'b0);
    look(3, 16'hff00);
    chk(XDATA_RDATA, 8'h00);
    // parity follows the accumulator, writes to it do not stick
    put(7, 16'h0000, 8'h07);
    look(0, 16'h00d0);
    chk(STATUS_WORD, 8'h19);
    put(7, 16'h0000, 8'h03);
    put(1, 16'h00d0, 8'h01);
    look(0, 16'h00d0);
    chk(SFR_RDATA, 8'h18);
    // arithmetic flags set and cleared
    put(5, 16'h0000, 8'h07);
    look(0, 16'h00d0);
    chk(STATUS_WORD, 8'hdc);
    put(5, 16'h0000, 8'h02);
    look(0, 16'h00d0);
    chk(STATUS_WORD, 8'h58);
    // user flags by bit writes, bit reads in and out of range
    put(1, 16'h00d5, 8'h01);
    put(1, 16'h00d1, 8'h01);
    look(1, 16'h00d5);
    chk(BIT_RDATA, 1'b1);
    chk(STATUS_WORD, 8'h7a);
    look(1, 16'h00d8);
    chk(BIT_HIT, 1'b0);
    // whole-byte write, then a bank bit cleared alone
    put(0, 16'h00d0, 8'hff);
    put(1, 16'h00d4, 8'h00);
    look(0, 16'h00d0);
    chk(SFR_RDATA, 8'hee);
    // second reset in mid-run clears registers and banks
    rst();
    look(0, 16'h0085);
    chk(SFR_RDATA, 8'h00);
    chk(STATUS_WORD, 8'h00);
    chk(ACTIVE_POINTER, 16'h0000);
    look(2, 16'h001f);
    chk(DATA_RDATA, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
